// ---- hw/hub_ind_pkg.sv ----
// How it works
// - Auto mode, powered-off port stays dark unless overcurrent removed power: amber
// - Auto mode: green for Enabled/Transmit/TransmitR, dark for all other states except overcurrent power-off
// - Lit outputs may be gated by a square wave to save power
// - Active level of every indicator pin is selectable by software
// - Manual mode: host request sets colour, held until host changes it
// - Manual mode supports blinking between the two requested states
// - Babble blinks green, overcurrent lights amber only, as host requests
// - Manual: off, steady amber, steady green per requested condition
// - Manual: off/green blink for software, off/amber blink for hardware
// - After reset every port runs in automatic mode
// - Automatic mode never blinks; only steady off, green or amber
// - Indicator support shows in bit 7 of hub feature word, default set
package hub_ind_pkg;

  localparam int            NPORTS     = 4;
  localparam int            CLK_MHZ    = 100;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int            BLINK_HALF_MS  = 500;
  localparam int            BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
  localparam int            MOD_HALF_US    = 50;
  localparam int            MOD_HALF_CYC   = MOD_HALF_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0]   CTRL_OFF    = 12'h000;
  localparam logic [11:0]   SELECT_OFF  = 12'h004;
  localparam logic [11:0]   STATUS_OFF  = 12'h008;
  localparam int            CTRL_POL_BIT = 0;
  localparam int            CTRL_MOD_BIT = 1;
  localparam int            CTRL_FIT_BIT = 2;
  localparam int            SEL_STRIDE   = 4;
  localparam int            FEAT_IND_BIT = 7;
  localparam int            STAT_AMB_POS = 16;
  localparam int            STAT_GRN_POS = 20;
  localparam logic          POL_RESET   = 1'b0;
  localparam logic          MOD_RESET   = 1'b0;
  localparam logic          FIT_RESET   = 1'b1;

  typedef enum logic [2:0] {
    SEL_AUTO    = 3'b000,
    SEL_AMBER   = 3'b001,
    SEL_GREEN   = 3'b010,
    SEL_OFF     = 3'b011,
    SEL_BLINK_G = 3'b100,
    SEL_BLINK_A = 3'b101,
    SEL_RSVD_GA = 3'b110,
    SEL_RSVD_7  = 3'b111
  } ind_sel_t;

  typedef enum logic [3:0] {
    PS_POWERED_OFF = 4'b0000,
    PS_DISCONNECT  = 4'b0001,
    PS_DISABLED    = 4'b0010,
    PS_NOT_CONFIG  = 4'b0011,
    PS_RESETTING   = 4'b0100,
    PS_TESTING     = 4'b0101,
    PS_ENABLED     = 4'b0110,
    PS_TRANSMIT    = 4'b0111,
    PS_TRANSMIT_R  = 4'b1000,
    PS_SUSPENDED   = 4'b1001,
    PS_RESUMING    = 4'b1010,
    PS_SEND_EOR    = 4'b1011,
    PS_RESTART_ES  = 4'b1100
  } port_state_t;

  typedef struct packed {
    logic        activeHigh;
    logic        modEnable;
    logic        fitted;
  } ind_ctrl_t;

  typedef struct packed {
    ind_ctrl_t                     ctrl;
    ind_sel_t    [NPORTS-1:0]      sel;
    logic        [31:0]            blinkCnt;
    logic                          blinkPhase;
    logic        [31:0]            modCnt;
    logic                          modPhase;
    logic        [NPORTS-1:0]      amberPin;
    logic        [NPORTS-1:0]      greenPin;
    logic        [31:0]            prdata;
    logic                          pready;
    logic                          pslverr;
  } ind_state_t;

endpackage

// ---- hw/hub_port_indicator_control.sv ----
`timescale 1ns/1ps
module hub_port_indicator_control #(
  parameter int BLINK_CYC = hub_ind_pkg::BLINK_HALF_CYC,
  parameter int MOD_CYC   = hub_ind_pkg::MOD_HALF_CYC
) (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              resetn,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Port status from the port state machines
  input  wire hub_ind_pkg::port_state_t [3:0]    portState,
  input  wire logic [3:0]                        ovrOff,
  // Indicator pins
  output logic      [3:0]                        amberLed,
  output logic      [3:0]                        greenLed
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hub_ind_pkg::ind_state_t s_q;
  hub_ind_pkg::ind_state_t s_d;

  logic [15:0] featWord;
  logic [3:0]  amberOn;
  logic [3:0]  greenOn;
  logic [3:0]  litAmb;
  logic [3:0]  litGrn;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    hub_ind_pkg::ind_sel_t code;
    logic                  apbAcc;
    logic                  apbDone;
    code    = hub_ind_pkg::SEL_AUTO;
    s_d     = s_q;
    apbAcc  = psel && penable && !s_q.pready;
    apbDone = psel && penable && s_q.pready;
    featWord = 16'h0000;
    featWord[hub_ind_pkg::FEAT_IND_BIT] = s_q.ctrl.fitted;

    // Blink and modulation timebases
    if (s_q.blinkCnt >= 32'(BLINK_CYC - 1)) begin
      s_d.blinkCnt   = 32'h0000_0000;
      s_d.blinkPhase = !s_q.blinkPhase;
    end else begin
      s_d.blinkCnt = s_q.blinkCnt + 32'h0000_0001;
    end
    if (s_q.modCnt >= 32'(MOD_CYC - 1)) begin
      s_d.modCnt   = 32'h0000_0000;
      s_d.modPhase = !s_q.modPhase;
    end else begin
      s_d.modCnt = s_q.modCnt + 32'h0000_0001;
    end

    // APB: one wait state, answer registered
    if (apbAcc) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (paddr == hub_ind_pkg::CTRL_OFF) begin
        s_d.prdata[hub_ind_pkg::CTRL_POL_BIT] = s_q.ctrl.activeHigh;
        s_d.prdata[hub_ind_pkg::CTRL_MOD_BIT] = s_q.ctrl.modEnable;
        s_d.prdata[hub_ind_pkg::CTRL_FIT_BIT] = s_q.ctrl.fitted;
      end else if (paddr == hub_ind_pkg::SELECT_OFF) begin
        for (int i = 0; i < 4; i++) begin
          s_d.prdata[i*hub_ind_pkg::SEL_STRIDE +: 3] = s_q.sel[i];
        end
      end else if (paddr == hub_ind_pkg::STATUS_OFF) begin
        s_d.prdata[15:0] = featWord;
        s_d.prdata[hub_ind_pkg::STAT_AMB_POS +: 4] = litAmb;
        s_d.prdata[hub_ind_pkg::STAT_GRN_POS +: 4] = litGrn;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else if (apbDone) begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (pwrite && paddr == hub_ind_pkg::CTRL_OFF) begin
        s_d.ctrl.activeHigh = pwdata[hub_ind_pkg::CTRL_POL_BIT];
        s_d.ctrl.modEnable  = pwdata[hub_ind_pkg::CTRL_MOD_BIT];
        s_d.ctrl.fitted     = pwdata[hub_ind_pkg::CTRL_FIT_BIT];
      end else if (pwrite && paddr == hub_ind_pkg::SELECT_OFF) begin
        for (int i = 0; i < 4; i++) begin
          code = hub_ind_pkg::ind_sel_t'(
                   pwdata[i*hub_ind_pkg::SEL_STRIDE +: 3]);
          // Reserved codes leave the port unchanged
          if (code != hub_ind_pkg::SEL_RSVD_GA &&
              code != hub_ind_pkg::SEL_RSVD_7) begin
            s_d.sel[i] = code;
          end
        end
      end
    end

    // Per-port colour selection
    for (int i = 0; i < 4; i++) begin
      amberOn[i] = 1'b0;
      greenOn[i] = 1'b0;
      case (s_q.sel[i])
        hub_ind_pkg::SEL_AUTO: begin
          // Steady levels only
          greenOn[i] = portState[i] == hub_ind_pkg::PS_ENABLED  ||
                       portState[i] == hub_ind_pkg::PS_TRANSMIT ||
                       portState[i] == hub_ind_pkg::PS_TRANSMIT_R;
          amberOn[i] = portState[i] == hub_ind_pkg::PS_POWERED_OFF &&
                       ovrOff[i];
        end
        hub_ind_pkg::SEL_AMBER: begin
          amberOn[i] = 1'b1;
        end
        hub_ind_pkg::SEL_GREEN: begin
          greenOn[i] = 1'b1;
        end
        hub_ind_pkg::SEL_BLINK_G: begin
          greenOn[i] = s_q.blinkPhase;
        end
        hub_ind_pkg::SEL_BLINK_A: begin
          amberOn[i] = s_q.blinkPhase;
        end
        default: begin
          amberOn[i] = 1'b0;
        end
      endcase
      litAmb[i] = amberOn[i] && s_q.ctrl.fitted;
      litGrn[i] = greenOn[i] && s_q.ctrl.fitted;
      if (s_q.ctrl.modEnable && !s_q.modPhase) begin
        litAmb[i] = 1'b0;
        litGrn[i] = 1'b0;
      end
      s_d.amberPin[i] = litAmb[i] == s_q.ctrl.activeHigh;
      s_d.greenPin[i] = litGrn[i] == s_q.ctrl.activeHigh;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.ctrl.activeHigh <= hub_ind_pkg::POL_RESET;
      s_q.ctrl.modEnable  <= hub_ind_pkg::MOD_RESET;
      s_q.ctrl.fitted     <= hub_ind_pkg::FIT_RESET;
      s_q.sel             <= '{default: hub_ind_pkg::SEL_AUTO};
      s_q.blinkCnt        <= 32'h0000_0000;
      s_q.blinkPhase      <= 1'b0;
      s_q.modCnt          <= 32'h0000_0000;
      s_q.modPhase        <= 1'b0;
      s_q.amberPin        <= 4'hf;
      s_q.greenPin        <= 4'hf;
      s_q.prdata          <= 32'h0000_0000;
      s_q.pready          <= 1'b0;
      s_q.pslverr         <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign amberLed = s_q.amberPin;
  assign greenLed = s_q.greenPin;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  auto_green_a: assert property (
    s_q.sel[0] == hub_ind_pkg::SEL_AUTO && s_q.ctrl.fitted &&
    !s_q.ctrl.modEnable && portState[0] == hub_ind_pkg::PS_ENABLED
    |=> greenLed[0] == $past(s_q.ctrl.activeHigh))
    else $error("auto green not lit");

  auto_dark_a: assert property (
    s_q.sel[0] == hub_ind_pkg::SEL_AUTO &&
    portState[0] == hub_ind_pkg::PS_SUSPENDED
    |=> greenLed[0] != $past(s_q.ctrl.activeHigh) &&
        amberLed[0] != $past(s_q.ctrl.activeHigh))
    else $error("auto dark state lit");

  auto_ovr_a: assert property (
    s_q.sel[1] == hub_ind_pkg::SEL_AUTO && s_q.ctrl.fitted &&
    !s_q.ctrl.modEnable && ovrOff[1] &&
    portState[1] == hub_ind_pkg::PS_POWERED_OFF
    |=> amberLed[1] == $past(s_q.ctrl.activeHigh))
    else $error("overcurrent amber missing");

  auto_steady_a: assert property (
    s_q.sel[0] == hub_ind_pkg::SEL_AUTO && !s_q.ctrl.modEnable &&
    $stable(portState[0]) && $stable(ovrOff[0]) && $stable(s_q.ctrl)
    ##1 s_q.sel[0] == hub_ind_pkg::SEL_AUTO && $stable(portState[0]) &&
    $stable(ovrOff[0]) && $stable(s_q.ctrl)
    |=> $stable(greenLed[0]) && $stable(amberLed[0]))
    else $error("auto mode blinked");

  blink_dark_a: assert property (
    s_q.sel[2] == hub_ind_pkg::SEL_BLINK_G && !s_q.blinkPhase
    |=> greenLed[2] != $past(s_q.ctrl.activeHigh) &&
        amberLed[2] != $past(s_q.ctrl.activeHigh))
    else $error("blink off phase lit");

  mod_gate_a: assert property (
    s_q.ctrl.modEnable && !s_q.modPhase
    |=> amberLed == {4{!$past(s_q.ctrl.activeHigh)}} &&
        greenLed == {4{!$past(s_q.ctrl.activeHigh)}})
    else $error("modulation off phase lit");

  reserved_a: assert property (
    psel && penable && s_q.pready && pwrite &&
    paddr == hub_ind_pkg::SELECT_OFF && pwdata[14:12] == 3'h6
    |=> s_q.sel[3] == $past(s_q.sel[3]))
    else $error("reserved pattern accepted");

  manual_hold_a: assert property (
    s_q.sel[3] != hub_ind_pkg::SEL_AUTO &&
    !(psel && penable && s_q.pready && pwrite)
    |=> s_q.sel[3] == $past(s_q.sel[3]))
    else $error("manual setting changed");

  apb_wait_a: assert property (
    psel && !penable ##1 psel && penable
    |-> !pready ##1 pready)
    else $error("apb wait state wrong");

  amber_only_a: assert property (
    s_q.sel[0] == hub_ind_pkg::SEL_AMBER
    |=> greenLed[0] != $past(s_q.ctrl.activeHigh))
    else $error("amber setting lit green");

  manual_amber_a: assert property (
    s_q.sel[0] == hub_ind_pkg::SEL_AMBER && s_q.ctrl.fitted &&
    !s_q.ctrl.modEnable
    |=> amberLed[0] == $past(s_q.ctrl.activeHigh))
    else $error("manual amber not lit");

  manual_green_a: assert property (
    s_q.sel[1] == hub_ind_pkg::SEL_GREEN && s_q.ctrl.fitted &&
    !s_q.ctrl.modEnable
    |=> greenLed[1] == $past(s_q.ctrl.activeHigh) &&
        amberLed[1] != $past(s_q.ctrl.activeHigh))
    else $error("manual green wrong");

  manual_off_a: assert property (
    s_q.sel[2] == hub_ind_pkg::SEL_OFF
    |=> greenLed[2] != $past(s_q.ctrl.activeHigh) &&
        amberLed[2] != $past(s_q.ctrl.activeHigh))
    else $error("manual off lit");

  blink_lit_a: assert property (
    s_q.sel[3] == hub_ind_pkg::SEL_BLINK_G && s_q.blinkPhase &&
    s_q.ctrl.fitted && !s_q.ctrl.modEnable
    |=> greenLed[3] == $past(s_q.ctrl.activeHigh) &&
        amberLed[3] != $past(s_q.ctrl.activeHigh))
    else $error("blink on phase dark");

  blink_amber_a: assert property (
    s_q.sel[2] == hub_ind_pkg::SEL_BLINK_A && s_q.blinkPhase &&
    s_q.ctrl.fitted && !s_q.ctrl.modEnable
    |=> amberLed[2] == $past(s_q.ctrl.activeHigh) &&
        greenLed[2] != $past(s_q.ctrl.activeHigh))
    else $error("amber blink on phase wrong");

  unfitted_dark_a: assert property (
    !s_q.ctrl.fitted
    |=> amberLed == {4{!$past(s_q.ctrl.activeHigh)}} &&
        greenLed == {4{!$past(s_q.ctrl.activeHigh)}})
    else $error("unfitted indicator lit");

  blink_wrap_a: assert property (
    s_q.blinkCnt >= 32'(BLINK_CYC - 1)
    |=> s_q.blinkCnt == 32'h0000_0000 &&
        s_q.blinkPhase != $past(s_q.blinkPhase))
    else $error("blink phase did not toggle");

  blink_hold_a: assert property (
    s_q.blinkCnt < 32'(BLINK_CYC - 1)
    |=> s_q.blinkPhase == $past(s_q.blinkPhase))
    else $error("blink phase toggled early");

  mod_wrap_a: assert property (
    s_q.modCnt >= 32'(MOD_CYC - 1)
    |=> s_q.modCnt == 32'h0000_0000 &&
        s_q.modPhase != $past(s_q.modPhase))
    else $error("modulation phase did not toggle");

  reset_auto_a: assert property (
    $rose(resetn) |-> {s_q.sel} == 12'h000)
    else $error("port not automatic after reset");

  unmapped_err_a: assert property (
    psel && penable && !s_q.pready &&
    paddr != hub_ind_pkg::CTRL_OFF && paddr != hub_ind_pkg::SELECT_OFF &&
    paddr != hub_ind_pkg::STATUS_OFF
    |=> pready && pslverr)
    else $error("unmapped access not refused");

  status_fit_a: assert property (
    psel && penable && !s_q.pready && !pwrite &&
    paddr == hub_ind_pkg::STATUS_OFF
    |=> prdata[hub_ind_pkg::FEAT_IND_BIT] == $past(s_q.ctrl.fitted))
    else $error("feature bit wrong");

endmodule

// ---- verification/hub_port_indicator_control_test.sv ----
`timescale 1ns/1ps
module hub_port_indicator_control_test;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                              ref_clk;
  logic                              resetn;
  logic                              psel;
  logic                              penable;
  logic                              pwrite;
  logic [11:0]                       paddr;
  logic [31:0]                       pwdata;
  logic [31:0]                       prdata;
  logic                              pready;
  logic                              pslverr;
  hub_ind_pkg::port_state_t [3:0]    portState;
  hub_ind_pkg::port_state_t [3:0]    ps;
  logic [3:0]                        ovrOff;
  logic [3:0]                        amberLed;
  logic [3:0]                        greenLed;
  logic [3:0]                        amberLit;
  logic [3:0]                        greenLit;
  logic [3:0]                        ea;
  logic [3:0]                        eg;
  logic                              pol;
  logic                              lastErr;
  logic [31:0]                       q;
  int                                n_fail;
  int                                n_tests;
  int                                na;
  int                                ng;
  int                                nt;

  hub_port_indicator_control #(.BLINK_CYC(8), .MOD_CYC(2))
    i_hub_port_indicator_control (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portState(portState), .ovrOff(ovrOff),
    .amberLed(amberLed), .greenLed(greenLed));

  led_model i_led_model (.amberLed(amberLed), .greenLed(greenLed),
    .activeHigh(pol), .amberLit(amberLit), .greenLit(greenLit));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) n_fail++;
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic count(input int p);
    logic prev;
    na = 0;
    ng = 0;
    nt = 0;
    prev = greenLit[p];
    repeat (40) begin
      @(posedge ref_clk);
      na += amberLit[p];
      ng += greenLit[p];
      nt += int'(greenLit[p] != prev);
      prev = greenLit[p];
    end
  endtask

  task automatic settle(input logic [3:0] o);
    portState <= ps;
    ovrOff <= o;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end

  initial begin
    {resetn, psel, penable, pwrite, pol} = '0;
    {paddr, pwdata, ovrOff, n_fail, n_tests} = '0;
    portState = '0;
    ps = '0;
    q = $urandom(86);
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, hub_ind_pkg::CTRL_OFF, '0);
    chk(q, 32'h4);
    apb(1'b0, hub_ind_pkg::SELECT_OFF, '0);
    chk(q, '0);
    apb(1'b0, hub_ind_pkg::STATUS_OFF, '0);
    chk(q[15:0], 16'h0080);
    apb(1'b0, 12'h00c, '0);
    chk({31'h0, lastErr}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    $display("reset test done");
    for (int k = 0; k < 30; k++) begin
      if (k == 10) begin
        apb(1'b1, hub_ind_pkg::CTRL_OFF, 32'h5);
        pol = 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
        ps[i] = hub_ind_pkg::port_state_t'($urandom_range(12));
        if (k == 0) ps[i] = hub_ind_pkg::PS_POWERED_OFF;
      end
      eg = $urandom_range(15);
      settle(eg);
      for (int i = 0; i < 4; i++) begin
        ea[i] = ps[i] == hub_ind_pkg::PS_POWERED_OFF && eg[i];
        eg[i] = ps[i] inside {hub_ind_pkg::PS_ENABLED,
          hub_ind_pkg::PS_TRANSMIT, hub_ind_pkg::PS_TRANSMIT_R};
      end
      chk({amberLit, greenLit}, {ea, eg});
      apb(1'b0, hub_ind_pkg::STATUS_OFF, '0);
      chk(q[23:16], {eg, ea});
    end
    $display("automatic test done");
    ps = {4{hub_ind_pkg::PS_ENABLED}};
    settle(4'h0);
    count(0);
    chk(na, 32'd0);
    chk(ng, 32'd40);
    chk(nt, 32'd0);
    apb(1'b1, hub_ind_pkg::CTRL_OFF, 32'h7);
    repeat (3) @(posedge ref_clk);
    count(1);
    chk(ng, 20);
    apb(1'b1, hub_ind_pkg::CTRL_OFF, 32'h5);
    ps = {4{hub_ind_pkg::PS_DISCONNECT}};
    settle(4'hf);
    apb(1'b1, hub_ind_pkg::SELECT_OFF, 32'h4321);
    repeat (3) @(posedge ref_clk);
    chk({amberLit[2:0], greenLit[2:0]}, 6'b001_010);
    count(3);
    chk(na, 32'd0);
    chk(32'(ng >= 16 && ng <= 24), 32'h0000_0001);
    chk(32'(nt > 3), 32'h0000_0001);
    apb(1'b1, hub_ind_pkg::SELECT_OFF, 32'h6521);
    apb(1'b0, hub_ind_pkg::SELECT_OFF, '0);
    chk(q, 32'h4521);
    count(2);
    chk(ng, 32'd0);
    chk(32'(na >= 16 && na <= 24), 32'h0000_0001);
    $display("manual test done");
    apb(1'b1, hub_ind_pkg::CTRL_OFF, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk({amberLit, greenLit}, 8'h00);
    apb(1'b0, hub_ind_pkg::STATUS_OFF, '0);
    chk(q[7], 1'b0);
    $display("fitting test done");
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({24'h0, amberLed, greenLed}, 32'h0000_00ff);
    resetn <= 1'b1;
    pol = 1'b0;
    @(posedge ref_clk);
    apb(1'b0, hub_ind_pkg::SELECT_OFF, '0);
    chk(q, '0);
    ps = {4{hub_ind_pkg::PS_ENABLED}};
    settle(4'h0);
    chk({24'h0, amberLit, greenLit}, 32'h0000_000f);
    $display("second reset test done");
    test_done();
  end
endmodule

// ---- verification/led_model.sv ----
`timescale 1ns/1ps
module led_model (
  // Pins from the block
  input  wire logic [3:0] amberLed,
  input  wire logic [3:0] greenLed,
  // Board fitting
  input  wire logic       activeHigh,
  // Colours seen
  output logic      [3:0] amberLit,
  output logic      [3:0] greenLit
);
  // Lamp lights at the fitted level
  assign amberLit = activeHigh ? amberLed : ~amberLed;
  assign greenLit = activeHigh ? greenLed : ~greenLed;
endmodule
